// [common/crs_pkg.sv]
package crs_pkg;
   // Register indices on the plain register port.
   localparam logic [2:0] CRS_ADDR_MAIN_CLK = 3'h0;
   localparam logic [2:0] CRS_ADDR_RC_TRIM = 3'h1;
   localparam logic [2:0] CRS_ADDR_INTEGRITY = 3'h2;
   // Reset values.
   localparam logic [7:0] CRS_MAIN_CLK_RST = 8'h00;
   localparam logic [7:0] CRS_RC_TRIM_RST = 8'hFF;
   // Field positions.
   localparam int CRS_BIT_SLOW = 0;
   localparam int CRS_BIT_CLKOUT = 1;
   localparam int CRS_BIT_WARN_IE = 0;
   localparam int CRS_BIT_WARN_F = 1;
   localparam int CRS_BIT_UV_RF = 2;
   localparam int CRS_BIT_PLL_LOCK = 3;
   localparam int CRS_BIT_WDG_RF = 4;
   // Slow-mode divide ratio and half period.
   localparam int CRS_SLOW_DIV = 32;
   localparam logic [4:0] CRS_SLOW_HALF = 5'h0F;
   // Stabilisation delays in CPU clock cycles.
   localparam logic [12:0] CRS_DLY_SHORT = 13'h0100;
   localparam logic [12:0] CRS_DLY_LONG = 13'h1000;
   // Vector fetch length in cycles.
   localparam logic [1:0] CRS_FETCH_CYC = 2'h2;
   // Minimum reset output pulse in ns, and its count at 125 MHz (rounded up).
   localparam int CRS_CLK_PERIOD_NS = 8;
   localparam int CRS_MIN_OUT_PULSE_NS = 800;
   localparam logic [7:0] CRS_MIN_OUT_CYC =
      8'((CRS_MIN_OUT_PULSE_NS + CRS_CLK_PERIOD_NS - 1) / CRS_CLK_PERIOD_NS);
   // PLL start-up delay in ns, and its count (rounded up).
   localparam int CRS_PLL_STARTUP_NS = 16000;
   localparam logic [12:0] CRS_PLL_STARTUP_CYC =
      13'((CRS_PLL_STARTUP_NS + CRS_CLK_PERIOD_NS - 1) / CRS_CLK_PERIOD_NS);
   // Reset vector address.
   localparam logic [15:0] CRS_RESET_VECTOR = 16'hFFFE;
   // Reset sequencer states.
   typedef enum logic [3:0] {
      CRS_ACTIVE = 4'b0001,
      CRS_STAB = 4'b0010,
      CRS_FETCH = 4'b0100,
      CRS_RUN = 4'b1000
   } crs_state_t;
endpackage

// [design/crs_clk_div.sv]
`timescale 1ns/100ps
// Glitch-free slow-mode enable generator: the CPU clock is gated to a one-in-32
// enable, and the mode only changes at a period boundary so no short pulse occurs.
module crs_clk_div
   import crs_pkg::*;
(
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic slow_mode_select,
   input wire logic run,
   output logic cpu_clk_en,
   output logic slow_active
);
   logic [4:0] cnt_r;
   logic [4:0] cnt_nxt;
   logic slow_r;
   logic slow_nxt;
   logic en_r;
   logic en_nxt;

   // Mode is taken only when the divider wraps, so the switch never cuts a period.
   always_comb begin
      cnt_nxt = cnt_r + 5'h01;
      slow_nxt = slow_r;
      en_nxt = 1'b0;
      if (cnt_r == 5'(CRS_SLOW_DIV - 1)) begin
         slow_nxt = slow_mode_select;
      end
      if (!run) begin
         en_nxt = 1'b0;
      end else if (slow_r) begin
         en_nxt = (cnt_r == 5'(CRS_SLOW_DIV - 1));
      end else begin
         en_nxt = 1'b1;
      end
   end

   // Divider registers.
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         cnt_r <= 5'h00;
         slow_r <= 1'b0;
         en_r <= 1'b0;
      end else begin
         cnt_r <= cnt_nxt;
         slow_r <= slow_nxt;
         en_r <= en_nxt;
      end
   end

   assign cpu_clk_en = en_r;
   assign slow_active = slow_r;
endmodule // crs_clk_div

// [design/crs_supervisor.sv]
// The address map and the address-and-strobe port were left to the implementer.
`timescale 1ns/100ps
// Summary of operation
// - Slow mode divides CPU clock by 32.
// - Clock-output bit drives main clock on pin.
// - Main clock register resets to zero.
// - Trim register resets FFh; 00h fastest.
// - Pin, undervoltage, watchdog, illegal opcode reset.
// - Reset pin low during stabilisation delay.
// - Phases: active, delay, two-cycle vector fetch.
// - Delay 256 for RC/external, 4096 crystal.
// - Vector fetched from top address pair.
// - PLL clock withheld for extra start-up.
// - Reset pin low detected, even in halt.
// - Watchdog underflow pulls pin low minimum time.
// - Undervoltage holds static reset and pin low.
// - Undervoltage reset enabled and threshold by option.
// - Warning comparator readable as live status.
// - Warning works only with undervoltage enabled.
// - Warning interrupt when enabled and unmasked.
// - Warning wakes from wait, not halt.
// - Halt freezes integrity register except reset-flag sets, detector runs.
// - Crystal keeps running through reset.
// - Warning flag bit 1, enable bit 0.
// - Watchdog flag bit 4, cleared by write/undervoltage.
// - Undervoltage flag bit 2, cleared by read.
module crs_supervisor
   import crs_pkg::*;
(
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic [2:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   input wire logic reset_pin_in,
   output logic reset_pin_out,
   output logic reset_pin_oe,
   input wire logic uv_detect,
   input wire logic aux_voltage_detector,
   input wire logic watchdog_underflow,
   input wire logic illegal_opcode,
   input wire logic opt_uv_enable,
   input wire logic [1:0] opt_uv_threshold,
   input wire logic opt_crystal_sel,
   input wire logic opt_pll_enable,
   input wire logic pll_locked,
   input wire logic halt_mode,
   input wire logic wait_mode,
   input wire logic cpu_irq_mask,
   input wire logic irq_ack,
   output logic cpu_reset,
   output logic vector_fetch,
   output logic [15:0] vector_addr,
   output logic cpu_clk_en,
   output logic pll_clk_release,
   output logic osc_keep_running,
   output logic clock_out_enable,
   output logic clock_out,
   output logic [7:0] rc_trim_value,
   output logic [1:0] uv_threshold,
   output logic supply_warning_irq,
   output logic wait_wake
);
   // Pin and analog inputs cross two flip-flops before use.
   logic [1:0] pin_sync_r;
   logic [1:0] uv_sync_r;
   logic [1:0] aux_sync_r;
   logic pin_low;
   logic uv_low;
   logic aux_low;
   // Recent history of our own pin drive, as seen by the synchroniser.
   logic [1:0] oe_hist_r;
   logic pin_mask;

   // Register state.
   logic slow_mode_select_r;
   logic slow_mode_select_nxt;
   logic clk_out_en_r;
   logic clk_out_en_nxt;
   logic [7:0] trim_r;
   logic [7:0] trim_nxt;
   logic warn_ie_r;
   logic warn_ie_nxt;
   logic warn_f_r;
   logic warn_f_nxt;
   logic uv_rf_r;
   logic uv_rf_nxt;
   logic wdg_rf_r;
   logic wdg_rf_nxt;
   logic warn_pend_r;
   logic warn_pend_nxt;
   logic [7:0] rdata_r;
   logic [7:0] rdata_nxt;

   // Sequencer state.
   crs_state_t state_r;
   crs_state_t state_nxt;
   logic [12:0] cnt_r;
   logic [12:0] cnt_nxt;
   logic [7:0] pulse_r;
   logic [7:0] pulse_nxt;
   logic [12:0] pll_cnt_r;
   logic [12:0] pll_cnt_nxt;
   logic pll_rel_r;
   logic pll_rel_nxt;
   logic clkout_r;
   logic slow_active;
   logic uv_reset;
   logic int_src;
   logic any_src;
   logic [12:0] dly_len;

   // Synchronisers; only the second stage feeds logic.
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         pin_sync_r <= 2'h3;
         uv_sync_r <= 2'h0;
         aux_sync_r <= 2'h0;
         oe_hist_r <= 2'h0;
      end else begin
         pin_sync_r <= {pin_sync_r[0], reset_pin_in};
         // The drive history shifts in step with the pin stages it has to cover.
         oe_hist_r <= {oe_hist_r[0], reset_pin_oe};
         uv_sync_r <= {uv_sync_r[0], uv_detect};
         aux_sync_r <= {aux_sync_r[0], aux_voltage_detector};
      end
   end

   assign pin_low = ~pin_sync_r[1];
   assign uv_low = uv_sync_r[1];
   assign aux_low = aux_sync_r[1];
   // Undervoltage reset only exists when the option enables it.
   assign uv_reset = uv_low & opt_uv_enable;
   assign int_src = uv_reset | watchdog_underflow | illegal_opcode;
   // Our own pin drive reads back low, and the echo trails the drive by the two
   // synchroniser stages, so the pin term is masked for that long after release too.
   // Without the trailing mask the fetch phase would see its own delay as a new reset.
   assign pin_mask = reset_pin_oe | oe_hist_r[0] | oe_hist_r[1];
   assign any_src = int_src | (pin_low & ~pin_mask);
   assign dly_len = opt_crystal_sel ? CRS_DLY_LONG : CRS_DLY_SHORT;

   // Reset sequencer next state.
   always_comb begin
      state_nxt = state_r;
      cnt_nxt = cnt_r;
      pulse_nxt = (pulse_r != 8'h00) ? pulse_r - 8'h01 : 8'h00;
      if (watchdog_underflow) begin
         pulse_nxt = CRS_MIN_OUT_CYC;
      end
      case (state_r)
         CRS_ACTIVE: begin
            cnt_nxt = 13'h0000;
            // Stay while any source or the minimum output pulse holds.
            if (!any_src && !uv_reset && pulse_r == 8'h00) begin
               state_nxt = CRS_STAB;
            end
         end
         CRS_STAB: begin
            if (any_src) begin
               cnt_nxt = 13'h0000;
               state_nxt = CRS_ACTIVE;
            end else if (cnt_r == dly_len - 13'h0001) begin
               cnt_nxt = 13'h0000;
               state_nxt = CRS_FETCH;
            end else begin
               cnt_nxt = cnt_r + 13'h0001;
            end
         end
         CRS_FETCH: begin
            // A source during the fetch aborts it, so the CPU never starts half reset.
            if (any_src) begin
               state_nxt = CRS_ACTIVE;
            end else if (cnt_r == 13'(CRS_FETCH_CYC) - 13'h0001) begin
               state_nxt = CRS_RUN;
            end else begin
               cnt_nxt = cnt_r + 13'h0001;
            end
         end
         CRS_RUN: begin
            // Any source while running starts the whole sequence again.
            if (any_src) begin
               state_nxt = CRS_ACTIVE;
            end
         end
         default: begin
            state_nxt = CRS_ACTIVE;
         end
      endcase
   end

   // PLL start-up counter restarts with every reset.
   always_comb begin
      pll_cnt_nxt = pll_cnt_r;
      pll_rel_nxt = pll_rel_r;
      if (state_r != CRS_RUN) begin
         pll_cnt_nxt = 13'h0000;
         pll_rel_nxt = ~opt_pll_enable;
      end else if (!pll_rel_r) begin
         if (pll_cnt_r == CRS_PLL_STARTUP_CYC - 13'h0001) begin
            pll_rel_nxt = 1'b1;
         end else begin
            pll_cnt_nxt = pll_cnt_r + 13'h0001;
         end
      end
   end

   // Register file and flag next values.
   always_comb begin
      slow_mode_select_nxt = slow_mode_select_r;
      clk_out_en_nxt = clk_out_en_r;
      trim_nxt = trim_r;
      warn_ie_nxt = warn_ie_r;
      warn_f_nxt = warn_f_r;
      uv_rf_nxt = uv_rf_r;
      wdg_rf_nxt = wdg_rf_r;
      warn_pend_nxt = warn_pend_r;
      rdata_nxt = 8'h00;
      // Read data stand one cycle only; unmapped indices read as zero.
      if (reg_rd) begin
         case (reg_addr)
            CRS_ADDR_MAIN_CLK: rdata_nxt = {6'h00, clk_out_en_r, slow_mode_select_r};
            CRS_ADDR_RC_TRIM: rdata_nxt = trim_r;
            CRS_ADDR_INTEGRITY: rdata_nxt = {3'h0, wdg_rf_r, pll_locked, uv_rf_r,
                                             warn_f_r, warn_ie_r};
            default: rdata_nxt = 8'h00;
         endcase
      end
      if (reg_wr && reg_addr == CRS_ADDR_MAIN_CLK) begin
         // Upper bits are reserved and never stored.
         slow_mode_select_nxt = reg_wdata[CRS_BIT_SLOW];
         clk_out_en_nxt = reg_wdata[CRS_BIT_CLKOUT];
      end
      if (reg_wr && reg_addr == CRS_ADDR_RC_TRIM) begin
         trim_nxt = reg_wdata;
      end
      // Halt freezes the integrity register except the hardware reset-flag sets; the comparator itself keeps running.
      if (!halt_mode) begin
         if (reg_wr && reg_addr == CRS_ADDR_INTEGRITY) begin
            warn_ie_nxt = reg_wdata[CRS_BIT_WARN_IE];
            if (!reg_wdata[CRS_BIT_WDG_RF]) begin
               wdg_rf_nxt = 1'b0;
            end
         end
         if (reg_rd && reg_addr == CRS_ADDR_INTEGRITY) begin
            uv_rf_nxt = 1'b0;
         end
         warn_f_nxt = aux_low & opt_uv_enable;
         if (irq_ack) begin
            warn_pend_nxt = 1'b0;
         end
         // Rising warning flag sets the pending bit; set beats the acknowledge.
         if (aux_low && opt_uv_enable && !warn_f_r) begin
            warn_pend_nxt = 1'b1;
         end
      end
      // Hardware sets win over software clears.
      if (watchdog_underflow) begin
         wdg_rf_nxt = 1'b1;
      end
      if (uv_reset) begin
         uv_rf_nxt = 1'b1;
         wdg_rf_nxt = 1'b0;
      end
   end

   // Registers; main clock and trim return to their reset values on any reset.
   always_ff @(posedge sys_clk) begin
      if (!rst_n || state_r == CRS_ACTIVE) begin
         slow_mode_select_r <= CRS_MAIN_CLK_RST[CRS_BIT_SLOW];
         clk_out_en_r <= CRS_MAIN_CLK_RST[CRS_BIT_CLKOUT];
         trim_r <= CRS_RC_TRIM_RST;
         warn_ie_r <= 1'b0;
         warn_pend_r <= 1'b0;
      end else begin
         slow_mode_select_r <= slow_mode_select_nxt;
         clk_out_en_r <= clk_out_en_nxt;
         trim_r <= trim_nxt;
         warn_ie_r <= warn_ie_nxt;
         warn_pend_r <= warn_pend_nxt;
      end
   end

   // Flags and sequencer; cause flags survive sequencer resets.
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         warn_f_r <= 1'b0;
         uv_rf_r <= 1'b0;
         wdg_rf_r <= 1'b0;
         rdata_r <= 8'h00;
         state_r <= CRS_ACTIVE;
         cnt_r <= 13'h0000;
         pulse_r <= 8'h00;
         pll_cnt_r <= 13'h0000;
         pll_rel_r <= 1'b0;
         clkout_r <= 1'b0;
      end else begin
         warn_f_r <= warn_f_nxt;
         uv_rf_r <= uv_rf_nxt;
         wdg_rf_r <= wdg_rf_nxt;
         rdata_r <= rdata_nxt;
         state_r <= state_nxt;
         cnt_r <= cnt_nxt;
         pulse_r <= pulse_nxt;
         pll_cnt_r <= pll_cnt_nxt;
         pll_rel_r <= pll_rel_nxt;
         clkout_r <= clk_out_en_r & ~clkout_r;
      end
   end

   // Slow-mode clock enable generator.
   crs_clk_div u_div (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .slow_mode_select(slow_mode_select_r),
      .run(state_r == CRS_RUN),
      .cpu_clk_en(cpu_clk_en),
      .slow_active(slow_active)
   );

   // Open-drain pin: drive low through active phase (internal causes) and delay.
   // The pin is only ever pulled low; the board pull-up supplies the high level.
   assign reset_pin_out = 1'b0;
   assign reset_pin_oe = (state_r == CRS_STAB) || (state_r == CRS_ACTIVE &&
                         (int_src || pulse_r != 8'h00));
   // The CPU stays held through the fetch and starts only in the run state.
   assign cpu_reset = (state_r != CRS_RUN);
   assign vector_fetch = (state_r == CRS_FETCH);
   assign vector_addr = CRS_RESET_VECTOR;
   assign pll_clk_release = pll_rel_r;
   assign osc_keep_running = 1'b1;
   assign clock_out_enable = clk_out_en_r;
   assign clock_out = clkout_r;
   assign rc_trim_value = trim_r;
   assign uv_threshold = opt_uv_threshold;
   assign reg_rdata = rdata_r;
   assign supply_warning_irq = warn_pend_r & warn_ie_r & ~cpu_irq_mask;
   assign wait_wake = supply_warning_irq & wait_mode & ~halt_mode;
endmodule // crs_supervisor

// [test/crs_board.sv]
`timescale 1ns/100ps
// Board side of the reset wire: pull-up, a reset switch and the device's open drain.
module crs_board (
   input wire logic pull_req,
   input wire logic reset_pin_oe,
   input wire logic reset_pin_out,
   output logic reset_pin_level
);
   // The pull-up wins only when nobody pulls low, so a released wire reads high.
   assign reset_pin_level = !(pull_req || (reset_pin_oe && !reset_pin_out));
endmodule // crs_board

// [test/crs_monitor.sv]
`timescale 1ns/100ps
// Port-level checker for the supervisor; everything runs on the system clock.
module crs_monitor (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic [2:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reset_pin_oe,
   input wire logic uv_detect,
   input wire logic watchdog_underflow,
   input wire logic opt_uv_enable,
   input wire logic cpu_irq_mask,
   input wire logic cpu_reset,
   input wire logic vector_fetch,
   input wire logic [15:0] vector_addr,
   input wire logic cpu_clk_en,
   input wire logic clock_out_enable,
   input wire logic clock_out,
   input wire logic [7:0] rc_trim_value,
   input wire logic supply_warning_irq
);
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!rst_n);

   // The fetch phase is exactly two cycles and follows a driven delay phase.
   a_fetch_two_cycles: assert property ($rose(vector_fetch) |=> vector_fetch ##1 !vector_fetch)
      else $error("vector fetch length wrong");
   a_fetch_vector: assert property (vector_fetch |-> vector_addr == 16'hFFFE)
      else $error("wrong reset vector address");
   a_delay_pin_low: assert property ($rose(vector_fetch) |-> $past(reset_pin_oe) && $past(cpu_reset))
      else $error("pin not driven before fetch");
   // Reset sources must pull the shared pin low: the watchdog from the next cycle, undervoltage within five cycles.
   a_wdg_pulse: assert property (watchdog_underflow |=> reset_pin_oe [*8])
      else $error("watchdog pulse too short");
   a_uv_hold: assert property ((opt_uv_enable && uv_detect) [*5] |-> reset_pin_oe && cpu_reset)
      else $error("undervoltage not holding reset");
   a_irq_gate: assert property (supply_warning_irq |-> !cpu_irq_mask)
      else $error("warning interrupt while masked");
   a_trim_write: assert property (reg_wr && reg_addr == 3'h1 && !cpu_reset |=> rc_trim_value == $past(reg_wdata))
      else $error("trim value not taken");
   a_clkout_toggle: assert property (clock_out_enable [*3] |-> clock_out != $past(clock_out))
      else $error("clock out not toggling");
   // A slow-mode gap must be long; a short one would be a glitch on the CPU clock.
   a_slow_gap: assert property (cpu_clk_en ##1 (!cpu_clk_en && !cpu_reset) |-> ##1 !cpu_clk_en [*8])
      else $error("slow mode enable gap too short");
   c_fetch: cover property ($rose(vector_fetch));
   c_wdg: cover property (watchdog_underflow);
   c_irq: cover property ($rose(supply_warning_irq));
endmodule // crs_monitor

bind crs_supervisor crs_monitor mon_u (.sys_clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr,
   .reset_pin_oe, .uv_detect, .watchdog_underflow, .opt_uv_enable, .cpu_irq_mask, .cpu_reset,
   .vector_fetch, .vector_addr, .cpu_clk_en, .clock_out_enable, .clock_out, .rc_trim_value,
   .supply_warning_irq);

// [test/crs_supervisor_tb.sv]
`timescale 1ns/100ps
module crs_supervisor_tb;
   import crs_pkg::*;
   typedef struct packed {logic [2:0] a; logic [7:0] d; logic [7:0] e;} crs_row_t;
   localparam crs_row_t ROWS [5] = '{'{3'h0, 8'h03, 8'h03}, '{3'h1, 8'h80, 8'h80},
      '{3'h1, 8'h00, 8'h00}, '{3'h5, 8'h5A, 8'h00}, '{3'h0, 8'h01, 8'h01}};
   logic sys_clk = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, pull_req = 1'b0;
   logic [2:0] reg_addr = 3'h0;
   logic [7:0] reg_wdata = 8'h00, reg_rdata, rc_trim_value, d;
   logic [1:0] opt_uv_threshold = 2'h1, uv_threshold;
   logic uv_detect = 1'b0, aux_voltage_detector = 1'b0, watchdog_underflow = 1'b0;
   logic illegal_opcode = 1'b0, opt_crystal_sel = 1'b0, cpu_irq_mask = 1'b0, irq_ack = 1'b0;
   logic opt_uv_enable = 1'b1, opt_pll_enable = 1'b0, pll_locked = 1'b0, halt_mode = 1'b0;
   logic wait_mode = 1'b0, pll_clk_release, wait_wake;
   logic [15:0] vector_addr;
   logic reset_pin_in, reset_pin_out, reset_pin_oe, cpu_reset, vector_fetch, cpu_clk_en;
   logic osc_keep_running, clock_out_enable, clock_out, supply_warning_irq;
   int errors = 0, checks_done = 0, cycles = 0, s, f, n;

   crs_supervisor dut_u (.sys_clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
      .reset_pin_in, .reset_pin_out, .reset_pin_oe, .uv_detect, .aux_voltage_detector,
      .watchdog_underflow, .illegal_opcode, .opt_uv_enable, .opt_uv_threshold,
      .opt_crystal_sel, .opt_pll_enable, .pll_locked, .halt_mode,
      .wait_mode, .cpu_irq_mask, .irq_ack, .cpu_reset, .vector_fetch, .vector_addr,
      .cpu_clk_en, .pll_clk_release, .osc_keep_running, .clock_out_enable, .clock_out,
      .rc_trim_value, .uv_threshold, .supply_warning_irq, .wait_wake);
   crs_board board_u (.pull_req, .reset_pin_oe, .reset_pin_out, .reset_pin_level(reset_pin_in));

   // Free-running 125 MHz clock.
   always #4 sys_clk = ~sys_clk;

   // A hang is cut short well beyond the longest expected run.
   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 20000) begin
         errors++;
         $display("mismatch at %0t: timeout", $time);
         conclude();
      end
   end

   task automatic conclude();
      $display("checks %0d, mismatches %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      checks_done++;
      if (got !== exp) begin
         errors++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic wr(input logic [2:0] a, input logic [7:0] v);
      @(posedge sys_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= v;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
   endtask

   // Read data stand only in the cycle after the strobe, so sample just then.
   task automatic rd(input logic [2:0] a, output logic [7:0] v);
      @(posedge sys_clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      #1 v = reg_rdata;
   endtask

   // Counts driven-pin and fetch cycles until the CPU leaves reset.
   task automatic run_seq(output int st, output int fe);
      st = 0;
      fe = 0;
      for (int i = 0; i < 6000 && cpu_reset !== 1'b0; i++) begin
         @(posedge sys_clk);
         #1;
         if (reset_pin_oe === 1'b1) st++;
         if (vector_fetch === 1'b1) fe++;
      end
   endtask

   // Main sequence: power-up, table, then the awkward cases one by one.
   initial begin
      repeat (10) @(posedge sys_clk);
      rst_n <= 1'b1;
      run_seq(s, f);
      chk(16'(s), 16'd256);
      chk(16'(f), 16'd2);
      rd(CRS_ADDR_MAIN_CLK, d);
      chk(d, 8'h00);
      rd(CRS_ADDR_RC_TRIM, d);
      chk(d, 8'hFF);
      chk(osc_keep_running, 1'b1);
      chk(uv_threshold, 2'h1);
      $display("test power-up done");
      foreach (ROWS[i]) begin
         wr(ROWS[i].a, ROWS[i].d);
         rd(ROWS[i].a, d);
         chk(d, ROWS[i].e);
      end
      chk(rc_trim_value, 8'h00);
      repeat (64) @(posedge sys_clk);
      n = 0;
      repeat (320) begin
         @(posedge sys_clk);
         #1;
         if (cpu_clk_en === 1'b1) n++;
      end
      chk(16'(n), 16'd10);
      wr(CRS_ADDR_MAIN_CLK, 8'h02);
      repeat (4) @(posedge sys_clk);
      #1 d[0] = clock_out;
      @(posedge sys_clk);
      #1 chk(clock_out, !d[0]);
      $display("test registers done");
      @(posedge sys_clk);
      illegal_opcode <= 1'b1;
      @(posedge sys_clk);
      illegal_opcode <= 1'b0;
      repeat (3) @(posedge sys_clk);
      #1 chk(cpu_reset, 1'b1);
      run_seq(s, f);
      rd(CRS_ADDR_RC_TRIM, d);
      chk(d, 8'hFF);
      rd(CRS_ADDR_MAIN_CLK, d);
      chk(d, 8'h00);
      @(posedge sys_clk);
      opt_crystal_sel <= 1'b1;
      pull_req <= 1'b1;
      repeat (20) @(posedge sys_clk);
      #1 chk(cpu_reset, 1'b1);
      @(posedge sys_clk);
      pull_req <= 1'b0;
      run_seq(s, f);
      chk(16'(s), 16'd4096);
      $display("test reset sources done");
      @(posedge sys_clk);
      opt_crystal_sel <= 1'b0;
      watchdog_underflow <= 1'b1;
      @(posedge sys_clk);
      watchdog_underflow <= 1'b0;
      repeat (2) @(posedge sys_clk);
      run_seq(s, f);
      chk(16'(s >= 350), 16'd1);
      rd(CRS_ADDR_INTEGRITY, d);
      chk(d[4], 1'b1);
      @(posedge sys_clk);
      uv_detect <= 1'b1;
      repeat (30) @(posedge sys_clk);
      #1 chk(reset_pin_oe, 1'b1);
      @(posedge sys_clk);
      uv_detect <= 1'b0;
      run_seq(s, f);
      rd(CRS_ADDR_INTEGRITY, d);
      chk(d & 8'h14, 8'h04);
      rd(CRS_ADDR_INTEGRITY, d);
      chk(d[2], 1'b0);
      $display("test flags done");
      wr(CRS_ADDR_INTEGRITY, 8'h01);
      aux_voltage_detector <= 1'b1;
      repeat (6) @(posedge sys_clk);
      #1 chk(supply_warning_irq, 1'b1);
      rd(CRS_ADDR_INTEGRITY, d);
      chk(d & 8'h03, 8'h03);
      @(posedge sys_clk);
      cpu_irq_mask <= 1'b1;
      @(posedge sys_clk);
      #1 chk(supply_warning_irq, 1'b0);
      @(posedge sys_clk);
      cpu_irq_mask <= 1'b0;
      irq_ack <= 1'b1;
      @(posedge sys_clk);
      irq_ack <= 1'b0;
      #1 chk(supply_warning_irq, 1'b0);
      $display("test warning done");
      @(posedge sys_clk);
      aux_voltage_detector <= 1'b0;
      repeat (4) @(posedge sys_clk);
      aux_voltage_detector <= 1'b1;
      wait_mode <= 1'b1;
      repeat (5) @(posedge sys_clk);
      #1 chk(wait_wake, 1'b1);
      @(posedge sys_clk);
      halt_mode <= 1'b1;
      @(posedge sys_clk);
      #1 chk(wait_wake, 1'b0);
      wr(CRS_ADDR_INTEGRITY, 8'h00);
      rd(CRS_ADDR_INTEGRITY, d);
      chk(d & 8'h03, 8'h03);
      @(posedge sys_clk);
      halt_mode <= 1'b0;
      wait_mode <= 1'b0;
      opt_uv_enable <= 1'b0;
      uv_detect <= 1'b1;
      pll_locked <= 1'b1;
      repeat (3) @(posedge sys_clk);
      rd(CRS_ADDR_INTEGRITY, d);
      chk(d & 8'h0A, 8'h08);
      chk(cpu_reset, 1'b0);
      @(posedge sys_clk);
      uv_detect <= 1'b0;
      opt_pll_enable <= 1'b1;
      illegal_opcode <= 1'b1;
      @(posedge sys_clk);
      illegal_opcode <= 1'b0;
      repeat (2) @(posedge sys_clk);
      run_seq(s, f);
      repeat (CRS_PLL_STARTUP_CYC - 13'h0001) @(posedge sys_clk);
      #1 chk(pll_clk_release, 1'b0);
      @(posedge sys_clk);
      #1 chk(pll_clk_release, 1'b1);
      $display("test modes done");
      conclude();
   end
endmodule // crs_supervisor_tb
